/* File: hw/fls_pkg.sv */
// Purpose: shared constants and types for the fault, lockup and sleep control
// Assumes: 32-bit classic wishbone register port, 20 MHz core clock
// Notes:   priorities are ranks, a lower rank is a more urgent exception
package fls_pkg;

    // register byte offsets
    localparam logic [3:0] FLS_OFS_CTRL = 4'h0;
    localparam logic [3:0] FLS_OFS_MASK = 4'h4;
    localparam logic [3:0] FLS_OFS_STAT = 4'h8;

    // control and mask register fields
    localparam int FLS_CTRL_AFTER = 1;  // sleep_after_handler
    localparam int FLS_CTRL_DEEP  = 2;  // deep_sleep_select
    localparam int FLS_CTRL_EVPND = 4;  // event_on_pending
    localparam int FLS_MASK_GIM   = 0;  // global_interrupt_mask

    // status register fields
    localparam int FLS_STAT_SLEEP = 0;
    localparam int FLS_STAT_DEEP  = 1;
    localparam int FLS_STAT_LOCK  = 2;
    localparam int FLS_STAT_LKNMI = 3;
    localparam int FLS_STAT_WEVT  = 4;

    // reset values
    localparam logic [2:0] FLS_CTRL_RST = 3'h0;
    localparam logic       FLS_GIM_RST  = 1'h0;

    // exception ranks
    localparam int         FLS_RANK_W     = 3;
    localparam logic [2:0] FLS_RANK_RESET = 3'h0;
    localparam logic [2:0] FLS_RANK_NMI   = 3'h1;
    localparam logic [2:0] FLS_RANK_HF    = 3'h2;
    localparam logic [2:0] FLS_RANK_THR   = 3'h7;

    // number of fault sources
    localparam int FLS_NFLT = 11;

    // core states, one-hot
    typedef enum logic [4:0] {
        FLS_RUN   = 5'h01,
        FLS_SLWFI = 5'h02,
        FLS_SLWFE = 5'h04,
        FLS_LKHF  = 5'h08,
        FLS_LKNMI = 5'h10
    } fls_state_e;

    // fault conditions reported by the execution logic
    typedef struct packed {
        logic sup_call_exec; // supervisor_call_instr executed
        logic sup_call_hi;   // at or above supervisor_call_exception prio
        logic brk_exec;      // breakpoint_instr executed
        logic dbg_attached;
        logic bus_err_ldst;
        logic fetch_nx;      // fetch from no_execute_region
        logic fetch_bus_err;
        logic vec_bus_err;
        logic undef_instr;
        logic tbit_zero;
        logic unaligned;
    } fls_fault_s;

    // execution context from the exception logic
    typedef struct packed {
        logic       in_nmi;
        logic       in_hf;
        logic       unstk_err;   // program_status_word unstack bus error
        logic       unstk_main;  // return used main_stack_pointer
        logic       ret_thread;  // handler finished, back to thread
        logic [2:0] cur_rank;
    } fls_ctx_s;

    // sleep related instruction strobes
    typedef struct packed {
        logic wait_int;  // wait_interrupt_instr
        logic wait_evt;  // wait_event_instr
        logic send_evt;  // send_event_instr
    } fls_instr_s;

    // pending exception from the interrupt controller
    typedef struct packed {
        logic       valid;
        logic [2:0] rank;
        logic       new_pend;  // pulse, an interrupt just became pending
    } fls_pend_s;

endpackage : fls_pkg

/* File: hw/fls_fault_merge.sv */
// Purpose: folds the fault conditions into one fault request
// Assumes: all inputs are single-cycle strobes in the core clock
// Notes:   purely combinational
`timescale 1ns/100ps
module fls_fault_merge (
    input  wire fls_pkg::fls_fault_s i_flt,
    output logic                     o_fault
);
    import fls_pkg::*;

    // each listed condition becomes a fault, supervisor call only at high priority, breakpoint only without debugger
    always_comb begin
        o_fault = (i_flt.sup_call_exec & i_flt.sup_call_hi)
                | (i_flt.brk_exec & ~i_flt.dbg_attached)
                | i_flt.undef_instr | i_flt.tbit_zero
                | i_flt.bus_err_ldst | i_flt.vec_bus_err
                | i_flt.fetch_nx | i_flt.fetch_bus_err
                | i_flt.unaligned;
    end

endmodule : fls_fault_merge

/* File: hw/fls_prio_cmp.sv */
// Purpose: decides whether a pending exception may wake or enter
// Assumes: lower rank is higher priority
// Notes:   the mask only holds back configurable priorities
`timescale 1ns/100ps
module fls_prio_cmp #(
    parameter int RW = 3
) (
    input  wire logic [RW-1:0] i_pend_rank,
    input  wire logic          i_pend_valid,
    input  wire logic [RW-1:0] i_cur_rank,
    input  wire logic          i_mask,
    input  wire logic [RW-1:0] i_fixed_rank,
    output logic               o_wake,
    output logic               o_enter
);
    import fls_pkg::*;

    // wake needs only more priority than the running level
    always_comb begin
        o_wake  = i_pend_valid & (i_pend_rank < i_cur_rank);
        o_enter = o_wake & (~i_mask | (i_pend_rank <= i_fixed_rank));
    end

endmodule : fls_prio_cmp

/* File: hw/fls_core_ctrl.sv */
// Purpose: fault escalation, lockup and low-power control of the core
// Assumes: all core inputs synchronous to i_clk, strobes last one cycle
// Notes:   registers over classic wishbone, ack one cycle after request
`timescale 1ns/100ps
module fls_core_ctrl (
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    // wishbone slave
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    input  wire logic                i_wb_we,
    input  wire logic [3:0]          i_wb_adr,
    input  wire logic [3:0]          i_wb_sel,
    input  wire logic [31:0]         i_wb_dat,
    output logic      [31:0]         o_wb_dat,
    output logic                     o_wb_ack,
    // core side
    input  wire fls_pkg::fls_fault_s i_flt,
    input  wire fls_pkg::fls_ctx_s   i_ctx,
    input  wire fls_pkg::fls_instr_s i_ins,
    input  wire fls_pkg::fls_pend_s  i_pend,
    input  wire logic                i_nmi,
    input  wire logic                i_dbg_halt,
    input  wire logic                i_ext_event,
    output logic                     o_hf_req,
    output logic                     o_exc_enter,
    output logic                     o_exec_stop,
    // system side
    output logic                     o_sleeping,
    output logic                     o_deep_sleep,
    output logic                     o_lockup
);
    import fls_pkg::*;

    // all state of the block
    typedef struct packed {
        fls_state_e  st;
        logic [2:0]  ctrl;      // after, deep, evpnd
        logic        gim;
        logic        ev_latch;
        logic        deep;
        logic        hf_req;
        logic        enter;
        logic        ack;
        logic [31:0] rdat;
        logic        slp;       // sleeping, registered for the pin
        logic        lock;      // lockup, registered for the pin
        logic        stop;      // execution stopped, registered
    } fls_regs_s;

    fls_regs_s r;
    fls_regs_s next_r;

    logic fault;
    logic wake;
    logic enter;
    logic ev_set;
    logic wb_req;
    logic after_sel;
    logic deep_sel;
    logic evpnd_sel;

    // fault sources folded to one request
    fls_fault_merge u_merge (
        .i_flt   (i_flt),
        .o_fault (fault)
    );

    // wake and entry qualification of the pending exception
    fls_prio_cmp #(
        .RW (FLS_RANK_W)
    ) u_prio (
        .i_pend_rank  (i_pend.rank),
        .i_pend_valid (i_pend.valid),
        .i_cur_rank   (i_ctx.cur_rank),
        .i_mask       (r.gim),
        .i_fixed_rank (FLS_RANK_HF),
        .o_wake       (wake),
        .o_enter      (enter)
    );

    // control bits unpacked
    assign after_sel = r.ctrl[0];
    assign deep_sel  = r.ctrl[1];
    assign evpnd_sel = r.ctrl[2];

    // event sources for the latch
    assign ev_set = i_ext_event
                  | i_ins.send_evt
                  | (evpnd_sel & i_pend.new_pend);

    assign wb_req = i_wb_cyc & i_wb_stb & ~r.ack;

    // next state
    always_comb begin
        next_r        = r;
        next_r.hf_req = 1'b0;
        next_r.enter  = 1'b0;
        next_r.ack    = 1'b0;

        // latch keeps a set that collides with the wait for event clear, not with the wake from FLS_SLWFE
        if (ev_set) begin
            next_r.ev_latch = 1'b1;
        end

        case (r.st)
            FLS_RUN: begin
                if (fault && i_ctx.in_nmi) begin
                    next_r.st = FLS_LKNMI;
                end else if (fault && i_ctx.in_hf) begin
                    next_r.st = FLS_LKHF;
                end else if (i_ctx.unstk_err && i_ctx.unstk_main) begin
                    // lockup flavour follows the handler in use
                    next_r.st = i_ctx.in_nmi ? FLS_LKNMI : FLS_LKHF;
                end else if (fault) begin
                    // severe fault outranks anything but reset and nmi
                    next_r.hf_req = (i_ctx.cur_rank > FLS_RANK_HF);
                end else if (i_ins.wait_int) begin
                    if (!wake) begin
                        next_r.st   = FLS_SLWFI;
                        next_r.deep = deep_sel;
                    end
                end else if (i_ins.wait_evt) begin
                    if (r.ev_latch) begin
                        next_r.ev_latch = ev_set;
                    end else begin
                        next_r.st   = FLS_SLWFE;
                        next_r.deep = deep_sel;
                    end
                end else if (i_ctx.ret_thread && after_sel && !wake) begin
                    next_r.st   = FLS_SLWFI;
                    next_r.deep = deep_sel;
                end else begin
                    next_r.enter = enter;
                end
            end
            FLS_SLWFI: begin
                // masked interrupts still wake, entry waits
                if (wake) begin
                    next_r.st    = FLS_RUN;
                    next_r.deep  = 1'b0;
                    next_r.enter = enter;
                end
            end
            FLS_SLWFE: begin
                if (wake || ev_set || r.ev_latch) begin
                    next_r.st       = FLS_RUN;
                    next_r.deep     = 1'b0;
                    next_r.ev_latch = 1'b0;
                    next_r.enter    = enter;
                end
            end
            FLS_LKHF: begin
                if (i_dbg_halt || i_nmi) begin
                    next_r.st = FLS_RUN;
                end
            end
            FLS_LKNMI: begin
                // a further nmi cannot release this lockup
                if (i_dbg_halt) begin
                    next_r.st = FLS_RUN;
                end
            end
            default: begin
                next_r.st = FLS_RUN;
            end
        endcase

        // state decode kept in flip-flops so the pins carry no gates
        next_r.slp  = (next_r.st == FLS_SLWFI) || (next_r.st == FLS_SLWFE);
        next_r.lock = (next_r.st == FLS_LKHF) || (next_r.st == FLS_LKNMI);
        next_r.stop = next_r.slp | next_r.lock;

        // register access, answered one cycle later
        if (wb_req) begin
            next_r.ack  = 1'b1;
            next_r.rdat = 32'h0;
            if (i_wb_adr == FLS_OFS_CTRL) begin
                next_r.rdat[FLS_CTRL_AFTER] = r.ctrl[0];
                next_r.rdat[FLS_CTRL_DEEP]  = r.ctrl[1];
                next_r.rdat[FLS_CTRL_EVPND] = r.ctrl[2];
                if (i_wb_we && i_wb_sel[0]) begin
                    next_r.ctrl = {i_wb_dat[FLS_CTRL_EVPND],
                                   i_wb_dat[FLS_CTRL_DEEP],
                                   i_wb_dat[FLS_CTRL_AFTER]};
                end
            end else if (i_wb_adr == FLS_OFS_MASK) begin
                next_r.rdat[FLS_MASK_GIM] = r.gim;
                if (i_wb_we && i_wb_sel[0]) begin
                    next_r.gim = i_wb_dat[FLS_MASK_GIM];
                end
            end else if (i_wb_adr == FLS_OFS_STAT) begin
                next_r.rdat[FLS_STAT_SLEEP] = r.st[1] | r.st[2];
                next_r.rdat[FLS_STAT_DEEP]  = r.deep;
                next_r.rdat[FLS_STAT_LOCK]  = r.st[3] | r.st[4];
                next_r.rdat[FLS_STAT_LKNMI] = r.st[4];
                next_r.rdat[FLS_STAT_WEVT]  = r.st[2];
            end else begin
                // unmapped: answered, reads zero, writes dropped
                next_r.rdat = 32'h0;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r.st       <= FLS_RUN;
            r.ctrl     <= FLS_CTRL_RST;
            r.gim      <= FLS_GIM_RST;
            r.ev_latch <= 1'b0;
            r.deep     <= 1'b0;
            r.hf_req   <= 1'b0;
            r.enter    <= 1'b0;
            r.ack      <= 1'b0;
            r.rdat     <= 32'h0;
            r.slp      <= 1'b0;
            r.lock     <= 1'b0;
            r.stop     <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    assign o_wb_dat     = r.rdat;
    assign o_wb_ack     = r.ack;
    assign o_hf_req     = r.hf_req;
    assign o_exc_enter  = r.enter;
    assign o_sleeping   = r.slp;
    assign o_deep_sleep = r.deep;
    assign o_lockup     = r.lock;
    assign o_exec_stop  = r.stop;

endmodule : fls_core_ctrl

/* File: bench/fls_core_ctrl_asserts.sv */
// Purpose: port-level checks of fault, lockup and sleep control
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   strobes count only while the core runs
`timescale 1ns/100ps
module fls_core_ctrl_asserts (
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire fls_pkg::fls_fault_s i_flt,
    input  wire fls_pkg::fls_ctx_s   i_ctx,
    input  wire fls_pkg::fls_instr_s i_ins,
    input  wire fls_pkg::fls_pend_s  i_pend,
    input  wire logic               i_nmi,
    input  wire logic               i_dbg_halt,
    input  wire logic               i_ext_event,
    input  wire logic               o_wb_ack,
    input  wire logic               o_hf_req,
    input  wire logic               o_exec_stop,
    input  wire logic               o_sleeping,
    input  wire logic               o_deep_sleep,
    input  wire logic               o_lockup
);
    import fls_pkg::*;
    logic flt_any;
    logic wake;
    // fault strobes that must escalate
    assign flt_any = (i_flt.sup_call_exec & i_flt.sup_call_hi) | (i_flt.brk_exec & ~i_flt.dbg_attached)
                   | (|i_flt[6:0]);
    // pending exception above the current level
    assign wake = i_pend.valid && (i_pend.rank < i_ctx.cur_rank);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // request, one-cycle answer, locked state
    sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
    sequence s_ack; o_wb_ack ##1 !o_wb_ack; endsequence
    sequence s_lock; o_lockup && o_exec_stop && !o_hf_req; endsequence
    AST_WB_ACK: assert property (s_req |=> s_ack)
        else $error("ack not one cycle pulse");
    AST_HF_REQ: assert property (
        !o_exec_stop && flt_any && !i_ctx.unstk_err && !i_ctx.in_nmi && !i_ctx.in_hf && i_ctx.cur_rank > 3'h2
        |=> o_hf_req && !o_lockup) else $error("fault not escalated");
    AST_LOCK_IN: assert property (
        !o_exec_stop && ((flt_any && (i_ctx.in_nmi || i_ctx.in_hf)) || (i_ctx.unstk_err && i_ctx.unstk_main))
        |=> s_lock) else $error("lockup not entered");
    AST_LOCK_HOLD: assert property (o_lockup && !i_nmi && !i_dbg_halt |=> o_lockup)
        else $error("lockup left without cause");
    AST_DBG_EXIT: assert property (o_lockup && i_dbg_halt |=> !o_lockup)
        else $error("debug halt kept lockup");
    AST_STOP: assert property (o_sleeping || o_lockup |-> o_exec_stop && !(o_sleeping && o_lockup))
        else $error("execution not stopped");
    AST_DEEP: assert property (o_deep_sleep |-> o_sleeping)
        else $error("deep sleep while awake");
    AST_WAIT_INT: assert property (!o_exec_stop && i_ins.wait_int && !flt_any && !i_ctx.unstk_err && !wake
        && !i_nmi |=> o_sleeping) else $error("wait for interrupt did not sleep");
    AST_WAIT_INT_WAKE: assert property (!o_exec_stop && i_ins.wait_int && wake |=> !o_sleeping)
        else $error("wait for interrupt slept with wake pending");
    AST_WAKE: assert property (o_sleeping && wake |=> !o_sleeping)
        else $error("no wake on pending exception");
    AST_SLEEP_HOLD: assert property (
        o_sleeping && !i_pend.valid && !i_pend.new_pend && !i_ext_event && !i_nmi && !i_dbg_halt
        && !$past(i_ext_event) && !$past(i_ins.send_evt) && !$past(i_pend.new_pend) |=> o_sleeping)
        else $error("woke without cause");
endmodule : fls_core_ctrl_asserts

/* File: bench/fls_evt_partner.sv */
// Purpose: event controller and clock gate beside the core
// Assumes: event lines synchronous to i_clk
// Notes:   event output lags the lines by one cycle
`timescale 1ns/100ps
module fls_evt_partner (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic [15:0] i_lines,
    input  wire logic        i_deep_sleep,
    output logic             o_event,
    output logic             o_periph_clk_en
);
    // merge the external lines into one event
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) o_event <= 1'b0;
        else o_event <= |i_lines;
    end
    // peripheral clocks stop only in deep sleep
    assign o_periph_clk_en = !i_deep_sleep;
endmodule : fls_evt_partner

/* File: bench/test_fls_core_ctrl.sv */
// Purpose: directed bench for fault, lockup and sleep control
// Assumes: inputs change by nonblocking assignment on the rising edge
// Notes:   registers reached by a classic wishbone master task
`timescale 1ns/100ps
module test_fls_core_ctrl;
    import fls_pkg::*;
    logic        clk, nrst, cyc, stb, we, nmi, dbg, evt, ack, hf, ent, stop, slp, deep, lk, pclk;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] lines;
    fls_fault_s  flt;
    fls_ctx_s    ctx;
    fls_instr_s  ins;
    fls_pend_s   pend;
    int          failures, n_tests;
    fls_core_ctrl i_dut (
        .i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_flt(flt), .i_ctx(ctx),
        .i_ins(ins), .i_pend(pend), .i_nmi(nmi), .i_dbg_halt(dbg), .i_ext_event(evt), .o_hf_req(hf),
        .o_exc_enter(ent), .o_exec_stop(stop), .o_sleeping(slp), .o_deep_sleep(deep), .o_lockup(lk));
    fls_evt_partner i_evt (.i_clk(clk), .i_nrst(nrst), .i_lines(lines), .i_deep_sleep(deep),
        .o_event(evt), .o_periph_clk_en(pclk));
    // verdict and end of run
    task summarize;
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // compare seen against expected
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one classic wishbone cycle, read data to q
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            failures++;
            summarize();
        end
        q = rdat;
        @(posedge clk);
        {cyc, stb} <= 2'b00;
    endtask : wb
    // one-cycle core strobes: cv is unstack error, return, new pending
    task pulse(input logic [2:0] iv, input logic [10:0] fv, input logic [2:0] cv);
        @(posedge clk);
        {ins, flt, ctx.unstk_err, ctx.ret_thread, pend.new_pend} <= {iv, fv, cv};
        @(posedge clk);
        {ins, flt, ctx.unstk_err, ctx.ret_thread, pend.new_pend} <= '0;
        #1;
    endtask : pulse
    // one-cycle nmi or debug halt
    task hit(input logic n, input logic d);
        @(posedge clk);
        {nmi, dbg} <= {n, d};
        @(posedge clk);
        {nmi, dbg} <= 2'b00;
        #1;
    endtask : hit
    // one-cycle pending exception of rank r
    task wk(input logic [2:0] r);
        @(posedge clk);
        {pend.valid, pend.rank} <= {1'b1, r};
        @(posedge clk);
        pend.valid <= 1'b0;
        #1;
    endtask : wk
    // external line pulse through the event controller
    task ev;
        @(posedge clk);
        lines <= 16'h0100;
        @(posedge clk);
        lines <= 16'h0000;
        @(posedge clk);
        #1;
    endtask : ev
    task t_regs;
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0);
        @(posedge clk);
        sel <= 4'hE;
        wb(1'b1, 4'h0, 32'h16);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0);
        @(posedge clk);
        sel <= 4'hF;
        wb(1'b1, 4'h0, 32'h16);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h16);
        wb(1'b1, 4'hC, 32'hFF);
        wb(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 4'h0, 32'h0);
    endtask : t_regs
    task t_fault;
        for (int i = 0; i < 7; i++) begin
            pulse(3'h0, 11'h001 << i, 3'h0);
            chk(hf, 1'b1);
        end
        pulse(3'h0, 11'h600, 3'h0);
        chk(hf, 1'b1);
        pulse(3'h0, 11'h400, 3'h0);
        chk(hf, 1'b0);
        pulse(3'h0, 11'h100, 3'h0);
        chk(hf, 1'b1);
        pulse(3'h0, 11'h180, 3'h0);
        chk(hf, 1'b0);
        @(posedge clk);
        ctx.cur_rank <= 3'h3;
        pulse(3'h0, 11'h004, 3'h0);
        chk({hf, lk}, 2'b10);
        @(posedge clk);
        ctx.cur_rank <= 3'h2;
        pulse(3'h0, 11'h004, 3'h0);
        chk({hf, lk}, 2'b00);
        @(posedge clk);
        {ctx.cur_rank, ctx.in_hf} <= {3'h7, 1'b1};
        pulse(3'h0, 11'h004, 3'h0);
        chk({lk, stop, hf}, 3'b110);
        pulse(3'h4, 11'h0, 3'h0);
        chk({lk, slp}, 2'b10);
        hit(1'b1, 1'b0);
        chk(lk, 1'b0);
        @(posedge clk);
        {ctx.in_hf, ctx.in_nmi} <= 2'b01;
        pulse(3'h0, 11'h040, 3'h0);
        hit(1'b1, 1'b0);
        chk(lk, 1'b1);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0C);
        hit(1'b0, 1'b1);
        chk(lk, 1'b0);
        @(posedge clk);
        {ctx.in_nmi, ctx.unstk_main} <= 2'b01;
        pulse(3'h0, 11'h0, 3'h4);
        chk(lk, 1'b1);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        chk(lk, 1'b0);
        @(posedge clk);
        {nrst, ctx.unstk_main} <= 2'b10;
    endtask : t_fault
    task t_sleep;
        pulse(3'h4, 11'h0, 3'h0);
        chk({slp, deep, stop}, 3'b101);
        pulse(3'h0, 11'h0, 3'h1);
        wk(3'h7);
        chk(slp, 1'b1);
        wk(3'h4);
        chk({slp, ent}, 2'b01);
        @(posedge clk);
        {pend.valid, pend.rank} <= {1'b1, 3'h4};
        pulse(3'h4, 11'h0, 3'h0);
        chk(slp, 1'b0);
        @(posedge clk);
        pend.valid <= 1'b0;
        wb(1'b1, 4'h4, 32'h1);
        pulse(3'h4, 11'h0, 3'h0);
        wk(3'h4);
        chk({slp, ent}, 2'b00);
        wb(1'b1, 4'h4, 32'h0);
        wb(1'b1, 4'h0, 32'h4);
        pulse(3'h4, 11'h0, 3'h0);
        chk({slp, deep, pclk}, 3'b110);
        wk(3'h3);
        chk(deep, 1'b0);
        wb(1'b1, 4'h0, 32'h2);
        pulse(3'h0, 11'h0, 3'h2);
        chk(slp, 1'b1);
        wk(3'h4);
        wb(1'b1, 4'h0, 32'h0);
        pulse(3'h0, 11'h0, 3'h2);
        chk(slp, 1'b0);
    endtask : t_sleep
    task t_wfe;
        pulse(3'h2, 11'h0, 3'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h11);
        ev();
        chk(slp, 1'b0);
        pulse(3'h1, 11'h0, 3'h0);
        pulse(3'h2, 11'h0, 3'h0);
        chk(slp, 1'b0);
        pulse(3'h2, 11'h0, 3'h0);
        chk(slp, 1'b1);
        ev();
        ev();
        pulse(3'h2, 11'h0, 3'h0);
        chk(slp, 1'b0);
        pulse(3'h2, 11'h0, 3'h0);
        pulse(3'h0, 11'h0, 3'h1);
        chk(slp, 1'b1);
        wb(1'b1, 4'h0, 32'h10);
        pulse(3'h0, 11'h0, 3'h1);
        chk(slp, 1'b0);
    endtask : t_wfe
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {nrst, cyc, stb, we, nmi, dbg, adr, wdat, lines, flt, ins, pend} = '0;
        sel = 4'hF;
        ctx = '0;
        ctx.cur_rank = 3'h7;
        failures = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_fault();
        t_sleep();
        t_wfe();
        summarize();
    end
endmodule : test_fls_core_ctrl
bind fls_core_ctrl fls_core_ctrl_asserts i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_flt(i_flt), .i_ctx(i_ctx), .i_ins(i_ins), .i_pend(i_pend), .i_nmi(i_nmi),
    .i_dbg_halt(i_dbg_halt), .i_ext_event(i_ext_event), .o_wb_ack(o_wb_ack), .o_hf_req(o_hf_req),
    .o_exec_stop(o_exec_stop), .o_sleeping(o_sleeping), .o_deep_sleep(o_deep_sleep), .o_lockup(o_lockup));
